// *** ilo_ops.sv ***
// Package of constants and the address and adder unit for indexed execution
`timescale 1ns/1ps
`default_nettype none
package ilo_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_INSTR  = 8'h04;
  localparam logic [7:0] OFS_ACCUM  = 8'h08;
  localparam logic [7:0] OFS_FRAME  = 8'h0c;
  localparam logic [7:0] OFS_BANK   = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_MADDR  = 8'h18;
  localparam logic [7:0] OFS_MDATA  = 8'h1c;
  // Field positions
  localparam int CTRL_EXT_BIT   = 0;
  localparam int STAT_C_BIT     = 0;
  localparam int STAT_DIGIT_BIT = 1;
  localparam int STAT_Z_BIT     = 2;
  localparam int STAT_OVFL_BIT  = 3;
  localparam int STAT_N_BIT     = 4;
  localparam int STAT_BUSY_BIT  = 8;
  localparam int STAT_UNSUP_BIT = 9;
  // Reset values
  localparam logic       EXT_RESET   = 1'b0;
  localparam logic [7:0] ACCUM_RESET = 8'h00;
  localparam logic [11:0] FRAME_RESET = 12'h000;
  localparam logic [3:0] BANK_RESET  = 4'h0;
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [15:0] INSTR_RESET = 16'h0000;
  // Opcode patterns
  localparam logic [5:0] OPC_ADD  = 6'b001001;
  localparam logic [3:0] OPC_BSET = 4'b1000;
  localparam logic [6:0] OPC_FILL = 7'b0110100;
  // Operand threshold and upper access bank page
  localparam logic [7:0] OFFSET_MAX  = 8'h5f;
  localparam logic [3:0] ACCESS_HIGH = 4'hf;
  localparam logic [7:0] FILL_VALUE  = 8'hff;
  // Quarter phase sequencer, Gray coded
  typedef enum logic [2:0] {
    QP_IDLE = 3'b000,
    QP_Q1   = 3'b001,
    QP_Q2   = 3'b011,
    QP_Q3   = 3'b010,
    QP_Q4   = 3'b110
  } ilo_phase_e;
endpackage : ilo_pkg

// =====================================================
// Effective address and add unit
module ilo_addr_alu (
  // Operand sources
  input  wire logic        ext_en_in,
  input  wire logic [15:0] instr_in,
  input  wire logic [11:0] frame_in,
  input  wire logic [3:0]  bank_in,
  input  wire logic [7:0]  accum_in,
  input  wire logic [7:0]  operand_in,
  // Results
  output logic      [11:0] addr_out,
  output logic             indexed_out,
  output logic      [7:0]  sum_out,
  output logic      [4:0]  flags_out
);
  wire logic [7:0] f_field  = instr_in[7:0];
  wire logic       acc_sel  = instr_in[8];
  wire logic       low_part = (f_field <= ilo_pkg::OFFSET_MAX);
  wire logic [8:0] sum9     = {1'b0, accum_in} + {1'b0, operand_in};
  wire logic [4:0] nib      = {1'b0, accum_in[3:0]} + {1'b0, operand_in[3:0]};

  assign indexed_out = ext_en_in && !acc_sel && low_part;
  assign addr_out = indexed_out ? frame_in + {4'h0, f_field} :
                    acc_sel ? {bank_in, f_field} :
                    low_part ? {4'h0, f_field} :
                    {ilo_pkg::ACCESS_HIGH, f_field};
  assign sum_out = sum9[7:0];
  // Status order: negative, overflow, zero, digit carry, carry
  assign flags_out = {sum9[7],
                      (accum_in[7] == operand_in[7]) &&
                      (sum9[7] != accum_in[7]),
                      sum9[7:0] == 8'h00,
                      nib[4],
                      sum9[8]};
endmodule : ilo_addr_alu
`default_nettype wire

// *** ilo_top.sv ***
// Indexed literal offset decode and execute block with AHB-Lite registers
//
// Behaviour
// - Extension on, low access operand becomes offset from frame pointer.
// - Add form adds accumulator to byte at frame pointer plus k.
// - Add result goes to accumulator if d is 0, else memory.
// - Add updates all five arithmetic flags; set-bit and fill keep flags.
// - Set-bit form sets bit b of byte at frame pointer plus k.
// - Fill form writes all ones into byte at frame pointer plus k.
// - Extension enable resets to 0, disabling indexed addressing.
// - Offset only with extension on and a=0; higher operands stay direct.
// - Extension off: a=0 access bank, a=1 bank select pointer bank.
//
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ilo_top (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic      [31:0] hrdata_out
);
  // =====================================================
  // Architectural state
  logic [7:0]  mem_r [0:4095];
  logic        ext_en_r;
  logic [15:0] instr_r;
  logic [7:0]  accum_r;
  logic [11:0] frame_r;
  logic [3:0]  bank_r;
  logic [4:0]  flags_r;
  logic [11:0] maddr_r;
  logic        unsup_r;
  ilo_pkg::ilo_phase_e phase_r;
  ilo_pkg::ilo_phase_e phase_nxt;
  logic [11:0] ea_r;
  logic [7:0]  operand_r;
  logic [7:0]  result_r;
  logic [4:0]  newflags_r;

  // =====================================================
  // Bus data phase tracking
  logic        dph_valid_r;
  logic        dph_write_r;
  logic [7:0]  dph_addr_r;
  logic        rd_ready_r;
  logic [31:0] hrdata_r;

  wire logic busy       = (phase_r != ilo_pkg::QP_IDLE);
  wire logic addr_take  = hsel_in && htrans_in[1] && hready_in;
  wire logic wr_done    = dph_valid_r && dph_write_r && !busy;
  wire logic rd_done    = dph_valid_r && !dph_write_r && rd_ready_r;
  // Accesses wait while an instruction runs, so memory has one writer
  assign hreadyout_out = !dph_valid_r || (!busy &&
                         (dph_write_r || rd_ready_r));
  assign hresp_out  = 1'b0;
  assign hrdata_out = hrdata_r;

  wire logic sel_ctrl  = (dph_addr_r == ilo_pkg::OFS_CTRL);
  wire logic sel_instr = (dph_addr_r == ilo_pkg::OFS_INSTR);
  wire logic sel_accum = (dph_addr_r == ilo_pkg::OFS_ACCUM);
  wire logic sel_frame = (dph_addr_r == ilo_pkg::OFS_FRAME);
  wire logic sel_bank  = (dph_addr_r == ilo_pkg::OFS_BANK);
  wire logic sel_stat  = (dph_addr_r == ilo_pkg::OFS_STATUS);
  wire logic sel_maddr = (dph_addr_r == ilo_pkg::OFS_MADDR);
  wire logic sel_mdata = (dph_addr_r == ilo_pkg::OFS_MDATA);

  wire logic [31:0] stat_word = {22'h0, unsup_r, busy, 3'h0, flags_r};
  wire logic [31:0] rd_mux =
    sel_ctrl  ? {31'h0, ext_en_r} :
    sel_instr ? {16'h0000, instr_r} :
    sel_accum ? {24'h000000, accum_r} :
    sel_frame ? {20'h00000, frame_r} :
    sel_bank  ? {28'h0000000, bank_r} :
    sel_stat  ? stat_word :
    sel_maddr ? {20'h00000, maddr_r} :
    sel_mdata ? {24'h000000, mem_r[maddr_r]} : 32'h00000000;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      dph_valid_r <= 1'b0;
      dph_write_r <= 1'b0;
      dph_addr_r  <= 8'h00;
    end else if (hreadyout_out) begin
      dph_valid_r <= addr_take;
      dph_write_r <= hwrite_in;
      dph_addr_r  <= (haddr_in[31:8] == 24'h000000) ? haddr_in[7:0] : 8'hfc;
    end
  end

  // Reads take one wait state so read data leaves a flip-flop
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rd_ready_r <= 1'b0;
      hrdata_r   <= 32'h00000000;
    end else if (rd_done) begin
      rd_ready_r <= 1'b0;
    end else if (dph_valid_r && !dph_write_r && !busy) begin
      rd_ready_r <= 1'b1;
      hrdata_r   <= rd_mux;
    end
  end

  // =====================================================
  // Decode
  wire logic is_add  = (instr_r[15:10] == ilo_pkg::OPC_ADD);
  wire logic is_bset = (instr_r[15:12] == ilo_pkg::OPC_BSET);
  wire logic is_fill = (instr_r[15:9] == ilo_pkg::OPC_FILL);
  wire logic dest_file = instr_r[9];
  wire logic [2:0] bit_pos = instr_r[11:9];
  wire logic [7:0] bit_mask = 8'h01 << bit_pos;

  logic [11:0] ea_comb;
  logic [7:0]  sum_comb;
  logic [4:0]  flags_comb;

  ilo_addr_alu u_alu (
    .ext_en_in   (ext_en_r),
    .instr_in    (instr_r),
    .frame_in    (frame_r),
    .bank_in     (bank_r),
    .accum_in    (accum_r),
    .operand_in  (operand_r),
    .addr_out    (ea_comb),
    .indexed_out (),
    .sum_out     (sum_comb),
    .flags_out   (flags_comb)
  );

  // =====================================================
  // Quarter phase sequencer
  always_comb begin
    case (phase_r)
      ilo_pkg::QP_IDLE: phase_nxt = ilo_pkg::QP_IDLE;
      ilo_pkg::QP_Q1:   phase_nxt = ilo_pkg::QP_Q2;
      ilo_pkg::QP_Q2:   phase_nxt = ilo_pkg::QP_Q3;
      ilo_pkg::QP_Q3:   phase_nxt = ilo_pkg::QP_Q4;
      ilo_pkg::QP_Q4:   phase_nxt = ilo_pkg::QP_IDLE;
      default:          phase_nxt = ilo_pkg::QP_IDLE;
    endcase
  end

  wire logic start = wr_done && sel_instr;
  wire logic known = is_add || is_bset || is_fill;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      phase_r <= ilo_pkg::QP_IDLE;
    end else if (start) begin
      phase_r <= ilo_pkg::QP_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // Q1 latch address, Q2 read, Q3 process
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ea_r       <= 12'h000;
      operand_r  <= 8'h00;
      result_r   <= 8'h00;
      newflags_r <= ilo_pkg::FLAGS_RESET;
    end else begin
      if (phase_r == ilo_pkg::QP_Q1) begin
        ea_r <= ea_comb;
      end
      if (phase_r == ilo_pkg::QP_Q2) begin
        operand_r <= mem_r[ea_r];
      end
      if (phase_r == ilo_pkg::QP_Q3) begin
        newflags_r <= flags_comb;
        if (is_add) begin
          result_r <= sum_comb;
        end else if (is_bset) begin
          result_r <= operand_r | bit_mask;
        end else begin
          result_r <= ilo_pkg::FILL_VALUE;
        end
      end
    end
  end

  // Q4 write to destination
  wire logic q4 = (phase_r == ilo_pkg::QP_Q4);
  wire logic exec_mem_wr = q4 && known && !(is_add && !dest_file);
  wire logic exec_acc_wr = q4 && is_add && !dest_file;

  always_ff @(posedge mclk_in) begin
    if (exec_mem_wr) begin
      mem_r[ea_r] <= result_r;
    end else if (wr_done && sel_mdata) begin
      mem_r[maddr_r] <= hwdata_in[7:0];
    end
  end

  // =====================================================
  // Software visible registers
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ext_en_r <= ilo_pkg::EXT_RESET;
      instr_r  <= ilo_pkg::INSTR_RESET;
      accum_r  <= ilo_pkg::ACCUM_RESET;
      frame_r  <= ilo_pkg::FRAME_RESET;
      bank_r   <= ilo_pkg::BANK_RESET;
      maddr_r  <= 12'h000;
    end else begin
      if (wr_done && sel_ctrl) begin
        ext_en_r <= hwdata_in[ilo_pkg::CTRL_EXT_BIT];
      end
      if (start) begin
        instr_r <= hwdata_in[15:0];
      end
      if (exec_acc_wr) begin
        accum_r <= result_r;
      end else if (wr_done && sel_accum) begin
        accum_r <= hwdata_in[7:0];
      end
      if (wr_done && sel_frame) begin
        frame_r <= hwdata_in[11:0];
      end
      if (wr_done && sel_bank) begin
        bank_r <= hwdata_in[3:0];
      end
      if (wr_done && sel_maddr) begin
        maddr_r <= hwdata_in[11:0];
      end
    end
  end

  // Flags change only for the add form and for a bus write to the status register
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      flags_r <= ilo_pkg::FLAGS_RESET;
      unsup_r <= 1'b0;
    end else begin
      if (q4 && is_add) begin
        flags_r <= newflags_r;
      end else if (wr_done && sel_stat) begin
        flags_r <= hwdata_in[4:0];
      end
      if (q4) begin
        unsup_r <= !known;
      end
    end
  end
endmodule : ilo_top
`default_nettype wire

// *** ilo_top_bench.sv ***
// Testbench for the indexed execution block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module ilo_top_bench;
  logic        mclk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic        hready;
  wire logic        hresp;
  wire logic [31:0] hrdata;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #10 mclk_in = ~mclk_in;
  ilo_top u_ilo_top (.mclk_in, .reset_in, .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata));
  // ==========
  // Bus tasks
  task results;
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // Far above the few hundred cycles the tests need
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  task automatic rdy;
    @(posedge mclk_in);
    while (hready !== 1'b1) @(posedge mclk_in);
  endtask : rdy
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
    rdy();
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    rdy();
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, {24'h0, a}, d, r);
  endtask : wr
  task automatic ck(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, {24'h0, a}, 32'h0, r);
    `CHK(r, e)
  endtask : ck
  task automatic mw(input logic [11:0] a, input logic [7:0] d);
    wr(ilo_pkg::OFS_MADDR, {20'h0, a});
    wr(ilo_pkg::OFS_MDATA, {24'h0, d});
  endtask : mw
  task automatic mc(input logic [11:0] a, input logic [7:0] e);
    wr(ilo_pkg::OFS_MADDR, {20'h0, a});
    ck(ilo_pkg::OFS_MDATA, {24'h0, e});
  endtask : mc
  // ==========
  // Scenarios
  task automatic t_reset;
    logic [31:0] r;
    ck(ilo_pkg::OFS_CTRL, 32'h0);
    xfer(1'b1, 32'h104, 32'hff, r);
    xfer(1'b0, 32'h100, 32'h0, r);
    `CHK(r, 32'h0)
    $display("test reset done");
  endtask : t_reset
  task automatic t_add;
    wr(ilo_pkg::OFS_CTRL, 32'h1);
    wr(ilo_pkg::OFS_FRAME, 32'ha00);
    mw(12'ha2c, 8'h20);
    wr(ilo_pkg::OFS_ACCUM, 32'h17);
    wr(ilo_pkg::OFS_INSTR, 32'h242c);
    ck(ilo_pkg::OFS_ACCUM, 32'h37);
    mc(12'ha2c, 8'h20);
    wr(ilo_pkg::OFS_INSTR, 32'h262c);
    mc(12'ha2c, 8'h57);
    ck(ilo_pkg::OFS_STATUS, 32'h0);
    mw(12'ha5f, 8'h80);
    wr(ilo_pkg::OFS_ACCUM, 32'h80);
    wr(ilo_pkg::OFS_INSTR, 32'h245f);
    ck(ilo_pkg::OFS_ACCUM, 32'h0);
    ck(ilo_pkg::OFS_STATUS, 32'h0d);
    mw(12'ha01, 8'h01);
    wr(ilo_pkg::OFS_ACCUM, 32'h7f);
    wr(ilo_pkg::OFS_INSTR, 32'h2601);
    mc(12'ha01, 8'h80);
    ck(ilo_pkg::OFS_STATUS, 32'h1a);
    $display("test add done");
  endtask : t_add
  task automatic t_bset;
    logic [7:0] e;
    e = 8'h0;
    mw(12'ha0a, 8'h00);
    for (int b = 0; b < 8; b++) begin
      wr(ilo_pkg::OFS_INSTR, 32'h800a | (b << 9));
      e[b] = 1'b1;
      mc(12'ha0a, e);
    end
    ck(ilo_pkg::OFS_STATUS, 32'h1a);
    $display("test bit set done");
  endtask : t_bset
  task automatic t_fill;
    mw(12'ha2c, 8'h00);
    wr(ilo_pkg::OFS_INSTR, 32'h682c);
    mc(12'ha2c, 8'hff);
    ck(ilo_pkg::OFS_STATUS, 32'h1a);
    mw(12'hf60, 8'h00);
    mw(12'ha60, 8'h00);
    wr(ilo_pkg::OFS_INSTR, 32'h6860);
    mc(12'hf60, 8'hff);
    mc(12'ha60, 8'h00);
    wr(ilo_pkg::OFS_BANK, 32'h3);
    mw(12'h32c, 8'h00);
    wr(ilo_pkg::OFS_INSTR, 32'h692c);
    mc(12'h32c, 8'hff);
    $display("test fill done");
  endtask : t_fill
  task automatic t_off;
    wr(ilo_pkg::OFS_CTRL, 32'h0);
    mw(12'h02c, 8'h00);
    mw(12'ha2c, 8'h00);
    wr(ilo_pkg::OFS_INSTR, 32'h682c);
    mc(12'h02c, 8'hff);
    mc(12'ha2c, 8'h00);
    mw(12'h32d, 8'h00);
    wr(ilo_pkg::OFS_INSTR, 32'h692d);
    mc(12'h32d, 8'hff);
    $display("test direct done");
  endtask : t_off
  task automatic t_unsup;
    mw(12'h02c, 8'h55);
    wr(ilo_pkg::OFS_INSTR, 32'h0000);
    ck(ilo_pkg::OFS_STATUS, 32'h21a);
    mc(12'h02c, 8'h55);
    wr(ilo_pkg::OFS_INSTR, 32'h8e2c);
    mc(12'h02c, 8'hd5);
    ck(ilo_pkg::OFS_STATUS, 32'h1a);
    $display("test unsupported done");
  endtask : t_unsup
  task automatic t_rerun;
    wr(ilo_pkg::OFS_CTRL, 32'h1);
    reset_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    ck(ilo_pkg::OFS_CTRL, 32'h0);
    ck(ilo_pkg::OFS_STATUS, 32'h0);
    ck(ilo_pkg::OFS_FRAME, 32'h0);
    $display("test reset again done");
  endtask : t_rerun
  initial begin
    repeat (12) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_reset();
    t_add();
    t_bset();
    t_fill();
    t_off();
    t_unsup();
    t_rerun();
    results();
  end
endmodule : ilo_top_bench
`default_nettype wire

// *** ilo_top_sva.sv ***
// Checker of bus timing and register field widths
`timescale 1ns/1ps
`default_nettype none
module ilo_top_chk (
  // Bus
  input wire logic        mclk_in,
  input wire logic        reset_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic [31:0] hrdata_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // ==========
  // Read tracking
  logic        rd_r;
  logic [31:0] ad_r;
  wire logic   take;
  wire logic   dn;
  wire logic   rdt;
  assign take = hsel_in & htrans_in[1] & hreadyout_out;
  assign rdt  = take & ~hwrite_in;
  assign dn   = rd_r & hreadyout_out & (ad_r[31:8] == 24'h0);
  always_ff @(posedge mclk_in) begin
    if (reset_in) rd_r <= 1'b0;
    else if (hreadyout_out) rd_r <= rdt;
  end
  always_ff @(posedge mclk_in) begin
    if (hreadyout_out) ad_r <= haddr_in;
  end
  // ==========
  // Assertions
  okay_resp_a: assert property (hresp_out == 1'b0)
    else $error("error response");
  read_wait_a: assert property (rdt |=> !hreadyout_out)
    else $error("read without wait state");
  read_bound_a: assert property (rdt |=> ##[1:6] hreadyout_out)
    else $error("read not answered");
  reset_idle_a: assert property (
    $fell(reset_in) |-> hreadyout_out && hrdata_out == 32'h0)
    else $error("not idle after reset");
  ctrl_bits_a: assert property (
    dn && ad_r[7:0] == ilo_pkg::OFS_CTRL |-> hrdata_out[31:1] == 31'h0)
    else $error("control spare bits set");
  stat_bits_a: assert property (
    dn && ad_r[7:0] == ilo_pkg::OFS_STATUS
    |-> hrdata_out[31:10] == 22'h0 && hrdata_out[7:5] == 3'h0)
    else $error("status spare bits set");
  mdata_bits_a: assert property (
    dn && ad_r[7:0] == ilo_pkg::OFS_MDATA |-> hrdata_out[31:8] == 24'h0)
    else $error("memory byte too wide");
  accum_bits_a: assert property (
    dn && ad_r[7:0] == ilo_pkg::OFS_ACCUM |-> hrdata_out[31:8] == 24'h0)
    else $error("accumulator too wide");
  cover property (dn && ad_r[7:0] == ilo_pkg::OFS_STATUS);
  cover property (take && hwrite_in && haddr_in[7:0] == ilo_pkg::OFS_INSTR);
  cover property (rdt ##1 !hreadyout_out [*3]);
endmodule : ilo_top_chk
bind ilo_top ilo_top_chk u_ilo_top_chk (.mclk_in, .reset_in, .hsel_in,
  .haddr_in, .htrans_in, .hwrite_in, .hreadyout_out, .hresp_out,
  .hrdata_out);
`default_nettype wire
